//--- addr_mode_pkg.sv
// Shared constants, mode enumeration and decode functions
package addr_mode_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  PREFIX_SECOND   = 8'h90;
  localparam logic [7:0]  PREFIX_INDIRECT = 8'h92;
  localparam logic [7:0]  PAGE_ZERO_HI    = 8'h00;
  localparam logic [15:0] PAGE_ZERO_LAST  = 16'h00FF;
  localparam logic [15:0] SHORT_IDX_LAST  = 16'h01FE;
  localparam logic [15:0] REL_BACK        = 16'h0080;
  localparam logic [15:0] REL_FWD         = 16'h007F;
  localparam logic [2:0]  LEN_INH         = 3'h1;
  localparam logic [2:0]  LEN_IMM         = 3'h2;
  localparam logic [2:0]  LEN_DIR_LONG    = 3'h3;

  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_IDXIND_S, M_IDXIND_L, M_REL_D, M_REL_I,
    M_BIT_D, M_BIT_I, M_BITREL_D, M_BITREL_I
  } mode_t;

  // Bytes that follow the opcode in the fetch stream
  function automatic logic [1:0] oper_bytes(input mode_t m);
    unique case (m)
      M_INH, M_IDX_0:              oper_bytes = 2'h0;
      M_DIR_L, M_IDX_L,
      M_BITREL_D, M_BITREL_I:      oper_bytes = 2'h2;
      default:                     oper_bytes = 2'h1;
    endcase
  endfunction

  // Pointer bytes read from page zero
  function automatic logic [1:0] ptr_reads(input mode_t m);
    unique case (m)
      M_IND_S, M_IDXIND_S, M_REL_I,
      M_BIT_I, M_BITREL_I:         ptr_reads = 2'h1;
      M_IND_L, M_IDXIND_L:         ptr_reads = 2'h2;
      default:                     ptr_reads = 2'h0;
    endcase
  endfunction

  function automatic logic is_long(input mode_t m);
    is_long = (m == M_DIR_L) || (m == M_IDX_L) ||
              (m == M_IND_L) || (m == M_IDXIND_L);
  endfunction

  // Indirect prefix turns direct and short or long indexed forms into indirect ones
  function automatic mode_t to_indirect(input mode_t m);
    unique case (m)
      M_DIR_S:    to_indirect = M_IND_S;
      M_DIR_L:    to_indirect = M_IND_L;
      M_IDX_S:    to_indirect = M_IDXIND_S;
      M_IDX_L:    to_indirect = M_IDXIND_L;
      M_REL_D:    to_indirect = M_REL_I;
      M_BIT_D:    to_indirect = M_BIT_I;
      M_BITREL_D: to_indirect = M_BITREL_I;
      default:    to_indirect = m;
    endcase
  endfunction

endpackage

//--- addressing_mode_decoder.sv
// Operand fetch and effective address sequencer of the core
`timescale 1ns/1ps

module addressing_mode_decoder (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  byte_valid,
  input  wire logic [7:0]            byte_data,
  output logic                       byte_ready,
  input  wire logic [15:0]           pc_start,
  input  wire addr_mode_pkg::mode_t  base_mode,
  input  wire logic                  rmw_op,
  input  wire logic [7:0]            index_x,
  input  wire logic [7:0]            index_y,
  output logic                       mem_req,
  output logic [15:0]                mem_addr,
  input  wire logic                  mem_ack,
  input  wire logic [7:0]            mem_rdata,
  output logic                       ea_valid,
  output logic [15:0]                ea,
  output logic [15:0]                branch_target,
  output logic [7:0]                 operand,
  output addr_mode_pkg::mode_t       mode_out,
  output logic                       use_second_index,
  output logic [2:0]                 instr_len,
  output logic                       bad_mode
);
  import addr_mode_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_OPC, S_OPER, S_PTR, S_DONE} fsm_t;

  typedef struct packed {
    fsm_t        st;
    logic        pre_seen;
    logic        pfx_y;
    logic        pfx_ind;
    mode_t       mode;
    logic        rmw;
    logic [1:0]  cnt;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [7:0]  idx;
    logic [15:0] pc_base;
    logic [2:0]  nbytes;
    logic        byte_ready;
    logic        mem_req;
    logic [15:0] mem_addr;
    logic        ea_valid;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0]  operand;
    mode_t       mode_out;
    logic        use_y;
    logic [2:0]  len;
    logic [15:0] pc_after;
    logic        bad;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   take_b;
  logic   take_m;
  mode_t  op_mode;

  ea_calc_if calc_bus ();

  ea_calc u_calc (
    .f (calc_bus)
  );

  assign take_b = byte_valid && s_reg.byte_ready;
  assign take_m = s_reg.mem_req && mem_ack;
  assign op_mode = s_reg.pfx_ind ? to_indirect(base_mode) : base_mode;

  assign calc_bus.mode     = s_reg.mode;
  assign calc_bus.b1       = s_reg.b1;
  assign calc_bus.b2       = s_reg.b2;
  assign calc_bus.p1       = s_reg.p1;
  assign calc_bus.p2       = s_reg.p2;
  assign calc_bus.idx      = s_reg.idx;
  assign calc_bus.pc_after = 16'(s_reg.pc_base + {13'h0000, s_reg.nbytes});

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.ea_valid = 1'b0;
    unique case (s_reg.st)
      S_OPC: begin
        if (take_b) begin
          s_next.nbytes = s_reg.nbytes + 3'h1;
          if (s_reg.nbytes == 3'h0) begin
            s_next.pc_base = pc_start;
          end
          // one prefix ahead of the opcode
          if (!s_reg.pre_seen && byte_data == PREFIX_SECOND) begin
            s_next.pre_seen = 1'b1;
            s_next.pfx_y    = 1'b1;
          end else if (!s_reg.pre_seen &&
                       byte_data == PREFIX_INDIRECT) begin
            s_next.pre_seen = 1'b1;
            s_next.pfx_ind  = 1'b1;
          end else begin
            s_next.mode = op_mode;
            s_next.rmw  = rmw_op;
            s_next.idx  = s_reg.pfx_y ? index_y : index_x;
            s_next.cnt  = 2'h0;
            s_next.st   = (oper_bytes(op_mode) != 2'h0) ? S_OPER
                                                        : S_DONE;
          end
        end
      end
      S_OPER: begin
        if (take_b) begin
          s_next.nbytes = s_reg.nbytes + 3'h1;
          s_next.cnt    = s_reg.cnt + 2'h1;
          if (s_reg.cnt == 2'h0) begin
            s_next.b1 = byte_data;
          end else begin
            s_next.b2 = byte_data;
          end
          if (s_reg.cnt + 2'h1 == oper_bytes(s_reg.mode)) begin
            s_next.cnt = 2'h0;
            s_next.st  = (ptr_reads(s_reg.mode) != 2'h0) ? S_PTR
                                                         : S_DONE;
          end
        end
      end
      S_PTR: begin
        if (take_m) begin
          s_next.cnt = s_reg.cnt + 2'h1;
          // Word pointers are stored high byte first
          if (s_reg.cnt == 2'h0) begin
            s_next.p1 = mem_rdata;
          end else begin
            s_next.p2 = mem_rdata;
          end
          if (s_reg.cnt + 2'h1 == ptr_reads(s_reg.mode)) begin
            s_next.st = S_DONE;
          end
        end
      end
      S_DONE: begin
        s_next.ea_valid = 1'b1;
        s_next.ea       = calc_bus.ea;
        s_next.target   = calc_bus.target;
        // byte after opcode is the operand
        s_next.operand  = s_reg.b1;
        s_next.mode_out = s_reg.mode;
        s_next.use_y    = s_reg.pfx_y;
        s_next.len      = s_reg.nbytes;
        s_next.pc_after = calc_bus.pc_after;
        s_next.bad      = s_reg.rmw && is_long(s_reg.mode);
        s_next.pre_seen = 1'b0;
        s_next.pfx_y    = 1'b0;
        s_next.pfx_ind  = 1'b0;
        s_next.nbytes   = 3'h0;
        s_next.st       = S_OPC;
      end
    endcase
    s_next.byte_ready = (s_next.st == S_OPC) || (s_next.st == S_OPER);
    // Request drops for one cycle after each ack so address can move
    s_next.mem_req    = (s_next.st == S_PTR) && !take_m;
    // pointer starts in page zero, next byte for low half, carrying to 0100 after 00FF
    s_next.mem_addr   = 16'({PAGE_ZERO_HI, s_next.b1} +
                            {14'h0000, s_next.cnt});
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign byte_ready       = s_reg.byte_ready;
  assign mem_req          = s_reg.mem_req;
  assign mem_addr         = s_reg.mem_addr;
  assign ea_valid         = s_reg.ea_valid;
  assign ea               = s_reg.ea;
  assign branch_target    = s_reg.target;
  assign operand          = s_reg.operand;
  assign mode_out         = s_reg.mode_out;
  assign use_second_index = s_reg.use_y;
  assign instr_len        = s_reg.len;
  assign bad_mode         = s_reg.bad;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  logic        op_take;
  logic [15:0] rel_diff;
  assign op_take  = take_b && s_reg.st == S_OPC &&
                    !(!s_reg.pre_seen && (byte_data == PREFIX_SECOND ||
                                          byte_data == PREFIX_INDIRECT));
  assign rel_diff = 16'(s_reg.ea - s_reg.pc_after);

  property p_inh_one_byte;
    op_take && !s_reg.pre_seen && base_mode == M_INH
      |-> ##2 (ea_valid && instr_len == LEN_INH);
  endproperty
  a_inh_one_byte: assert property (p_inh_one_byte)
    else $error("inherent not finished as one byte");

  property p_imm_operand;
    take_b && s_reg.st == S_OPER && s_reg.mode == M_IMM
      |-> ##2 (ea_valid && operand == $past(byte_data, 2));
  endproperty
  a_imm_operand: assert property (p_imm_operand)
    else $error("immediate operand not the byte after opcode");

  property p_dir_short;
    ea_valid && mode_out == M_DIR_S |-> ea <= PAGE_ZERO_LAST;
  endproperty
  a_dir_short: assert property (p_dir_short)
    else $error("short direct outside page zero");

  property p_dir_long_len;
    ea_valid && mode_out == M_DIR_L && !use_second_index
      |-> instr_len == LEN_DIR_LONG || instr_len == LEN_DIR_LONG + 3'h1;
  endproperty
  a_dir_long_len: assert property (p_dir_long_len)
    else $error("long direct length wrong");

  property p_idx_short;
    ea_valid && mode_out == M_IDX_S |-> ea <= SHORT_IDX_LAST;
  endproperty
  a_idx_short: assert property (p_idx_short)
    else $error("short indexed beyond 1FE");

  property p_ptr_page0;
    mem_req && s_reg.cnt == 2'h0 |-> mem_addr <= PAGE_ZERO_LAST;
  endproperty
  a_ptr_page0: assert property (p_ptr_page0)
    else $error("pointer not in page zero");

  property p_ptr_second;
    mem_req && s_reg.cnt == 2'h1
      |-> mem_addr == 16'({PAGE_ZERO_HI, s_reg.b1} + 16'h0001);
  endproperty
  a_ptr_second: assert property (p_ptr_second)
    else $error("second pointer byte not consecutive");

  property p_rel_range;
    ea_valid && (mode_out == M_REL_D || mode_out == M_REL_I)
      |-> rel_diff <= REL_FWD || rel_diff >= 16'(16'h0000 - REL_BACK);
  endproperty
  a_rel_range: assert property (p_rel_range)
    else $error("relative target out of range");

  property p_rmw_long;
    ea_valid && is_long(mode_out) && $past(s_reg.rmw) |-> bad_mode;
  endproperty
  a_rmw_long: assert property (p_rmw_long)
    else $error("long mode on read-modify-write not flagged");

  property p_prefix_ind;
    op_take && s_reg.pfx_ind && base_mode == M_DIR_S
      |=> s_reg.mode == M_IND_S;
  endproperty
  a_prefix_ind: assert property (p_prefix_ind)
    else $error("indirect prefix did not convert direct form");

  property p_prefix_y;
    op_take && s_reg.pfx_y |=> s_reg.idx == $past(index_y);
  endproperty
  a_prefix_y: assert property (p_prefix_y)
    else $error("second index prefix ignored");

endmodule

//--- ea_calc.sv
// Effective address and branch target arithmetic
`timescale 1ns/1ps
module ea_calc (
  ea_calc_if.calc f
);
  import addr_mode_pkg::*;

  logic [15:0] idx16;
  logic [15:0] word_b;
  logic [15:0] word_p;

  assign idx16  = {8'h00, f.idx};
  assign word_b = {f.b1, f.b2};
  assign word_p = {f.p1, f.p2};

  always_comb begin
    f.ea     = 16'h0000;
    f.target = 16'h0000;
    unique case (f.mode)
      M_INH, M_IMM: begin
        f.ea = 16'h0000;
      end
      M_DIR_S, M_BIT_D: f.ea = {PAGE_ZERO_HI, f.b1};
      M_DIR_L: f.ea = word_b;
      M_IDX_0: f.ea = idx16;
      M_IDX_S: f.ea = 16'({PAGE_ZERO_HI, f.b1} + idx16);
      M_IDX_L: f.ea = 16'(word_b + idx16);
      M_IND_S, M_BIT_I: f.ea = {PAGE_ZERO_HI, f.p1};
      M_IND_L: f.ea = word_p;
      M_IDXIND_S: f.ea = 16'({PAGE_ZERO_HI, f.p1} + idx16);
      M_IDXIND_L: f.ea = 16'(word_p + idx16);
      M_REL_D: f.ea = 16'(f.pc_after + {{8{f.b1[7]}}, f.b1});
      M_REL_I: f.ea = 16'(f.pc_after + {{8{f.p1[7]}}, f.p1});
      M_BITREL_D: begin
        f.ea     = {PAGE_ZERO_HI, f.b1};
        f.target = 16'(f.pc_after + {{8{f.b2[7]}}, f.b2});
      end
      M_BITREL_I: begin
        f.ea     = {PAGE_ZERO_HI, f.p1};
        f.target = 16'(f.pc_after + {{8{f.b2[7]}}, f.b2});
      end
    endcase
    if (f.mode == M_REL_D || f.mode == M_REL_I) begin
      f.target = f.ea;
    end
  end
endmodule

//--- ea_calc_if.sv
// Operand fields and resulting addresses between sequencer and adder
`timescale 1ns/1ps
interface ea_calc_if;
  import addr_mode_pkg::*;
  mode_t       mode;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  p1;
  logic [7:0]  p2;
  logic [7:0]  idx;
  logic [15:0] pc_after;
  logic [15:0] ea;
  logic [15:0] target;

  modport seq  (output mode, b1, b2, p1, p2, idx, pc_after,
                input ea, target);
  modport calc (input mode, b1, b2, p1, p2, idx, pc_after,
                output ea, target);
endinterface

//--- ptr_mem_model.sv
// Page-zero pointer memory answering the block's pointer reads
`timescale 1ns/1ps
module ptr_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  lat,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  logic [1:0] wait_cnt;

  // Contents are a fixed pattern of the address
  function automatic logic [7:0] mdat(input logic [15:0] a);
    mdat = a[7:0] ^ 8'hA5 ^ a[15:8];
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 8'h00;
      wait_cnt  <= 2'h0;
    end else if (mem_req && !mem_ack && wait_cnt == lat) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mdat(mem_addr);
      wait_cnt  <= 2'h0;
    end else begin
      // Stale data is scrambled so it never looks valid
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the addressing mode decoder
`timescale 1ns/1ps
module tb;
  import addr_mode_pkg::*;
  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] tgt;
    logic [7:0]  op;
    mode_t       mode;
    logic        sec;
    logic [2:0]  len;
    logic        bad;
    logic        chk_ea;
    logic        chk_op;
  } exp_t;

  logic sys_clk = 1'b0, resetn = 1'b0, byte_valid = 1'b0, rmw_op = 1'b0;
  logic [7:0]  byte_data = 8'h00, index_x = 8'h00, index_y = 8'h00;
  logic [15:0] pc_start = 16'h0000;
  mode_t       base_mode = M_INH;
  logic [1:0]  lat = 2'h0;
  logic byte_ready, mem_req, mem_ack, ea_valid, use_second_index, bad_mode;
  logic [15:0] mem_addr, ea, branch_target;
  logic [7:0]  mem_rdata, operand;
  mode_t       mode_out;
  logic [2:0]  instr_len;
  int mismatches = 0, compares = 0, seed = 51, i;
  logic [7:0]  rb;
  exp_t q[$];
  exp_t w;

  addressing_mode_decoder dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .pc_start(pc_start), .base_mode(base_mode),
    .rmw_op(rmw_op), .index_x(index_x), .index_y(index_y),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .ea_valid(ea_valid), .ea(ea),
    .branch_target(branch_target), .operand(operand),
    .mode_out(mode_out), .use_second_index(use_second_index),
    .instr_len(instr_len), .bad_mode(bad_mode));
  ptr_mem_model mem_u (.sys_clk(sys_clk), .resetn(resetn),
    .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] mdat(input logic [15:0] a);
    mdat = a[7:0] ^ 8'hA5 ^ a[15:8];
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Holds the byte until an edge at which the block is ready
  task automatic put(input logic [7:0] b);
    byte_valid <= 1'b1;
    byte_data  <= b;
    forever begin
      @(negedge sys_clk);
      if (byte_ready === 1'b1) break;
    end
    @(posedge sys_clk);
  endtask

  task automatic run(input logic [7:0] pre, input mode_t m, input logic rmw,
                     input logic [7:0] b1, input logic [7:0] b2);
    exp_t e;
    mode_t fm;
    int nb, k;
    logic [7:0] ix, iy, ixx, p;
    logic [15:0] pc, pa, pw;
    fm = m;
    // prefix turns direct and short or long indexed forms indirect
    if (pre == PREFIX_INDIRECT) begin
      case (m)
        M_DIR_S:    fm = M_IND_S;
        M_DIR_L:    fm = M_IND_L;
        M_IDX_S:    fm = M_IDXIND_S;
        M_IDX_L:    fm = M_IDXIND_L;
        M_REL_D:    fm = M_REL_I;
        M_BIT_D:    fm = M_BIT_I;
        M_BITREL_D: fm = M_BITREL_I;
        default:    fm = m;
      endcase
    end
    ix = 8'($random(seed));
    iy = 8'($random(seed));
    pc = 16'($random(seed));
    ixx = (pre == PREFIX_SECOND) ? iy : ix;
    nb = (fm == M_INH || fm == M_IDX_0) ? 0 :
         (fm == M_DIR_L || fm == M_IDX_L || fm == M_BITREL_D ||
          fm == M_BITREL_I) ? 2 : 1;
    e.len = 3'(nb + 1 + ((pre != 8'h00) ? 1 : 0));
    e.tgt = 16'h0000;
    e.op = b1;
    e.mode = fm;
    e.sec = (pre == PREFIX_SECOND);
    e.bad = rmw && (fm == M_DIR_L || fm == M_IDX_L || fm == M_IND_L ||
                    fm == M_IDXIND_L);
    e.chk_ea = (fm != M_INH && fm != M_IMM);
    e.chk_op = (nb != 0);
    pa = pc + 16'(e.len);
    // Pointer word is high byte first, low byte at pointer plus one
    p  = mdat({8'h00, b1});
    pw = {p, mdat({8'h00, b1} + 16'h0001)};
    case (fm)
      M_DIR_S, M_BIT_D: e.ea = {8'h00, b1};
      M_DIR_L: e.ea = {b1, b2};
      M_IDX_0: e.ea = {8'h00, ixx};
      M_IDX_S: e.ea = {8'h00, b1} + {8'h00, ixx};
      M_IDX_L: e.ea = {b1, b2} + {8'h00, ixx};
      M_IND_S, M_BIT_I: e.ea = {8'h00, p};
      M_IND_L: e.ea = pw;
      M_IDXIND_S: e.ea = {8'h00, p} + {8'h00, ixx};
      M_IDXIND_L: e.ea = pw + {8'h00, ixx};
      M_REL_D: begin
        e.ea = pa + {{8{b1[7]}}, b1};
        e.tgt = e.ea;
      end
      M_REL_I: begin
        e.ea = pa + {{8{p[7]}}, p};
        e.tgt = e.ea;
      end
      M_BITREL_D: begin
        e.ea = {8'h00, b1};
        e.tgt = pa + {{8{b2[7]}}, b2};
      end
      M_BITREL_I: begin
        e.ea = {8'h00, p};
        e.tgt = pa + {{8{b2[7]}}, b2};
      end
      default: e.ea = 16'h0000;
    endcase
    q.push_back(e);
    base_mode <= m;
    rmw_op    <= rmw;
    index_x   <= ix;
    index_y   <= iy;
    pc_start  <= pc;
    if (pre != 8'h00) put(pre);
    put({4'hA, 4'($random(seed))});
    if (nb > 0) put(b1);
    if (nb > 1) put(b2);
    byte_valid <= 1'b0;
    for (k = 0; k < 60 && q.size() != 0; k++) @(posedge sys_clk);
    if (q.size() != 0) begin
      mismatches++;
      $display("Error at %0t: no result for mode %0d", $time, m);
      q.delete();
    end
  endtask

  always @(negedge sys_clk) begin
    if (ea_valid === 1'b1) begin
      if (q.size() == 0) begin
        mismatches++;
        $display("Error at %0t: result without request", $time);
      end else begin
        w = q.pop_front();
        if (w.chk_ea) cmp(ea, w.ea, "ea");
        cmp(branch_target, w.tgt, "target");
        if (w.chk_op) cmp(16'(operand), 16'(w.op), "operand");
        cmp(16'(mode_out), 16'(w.mode), "mode");
        cmp(16'(use_second_index), 16'(w.sec), "second");
        cmp(16'(instr_len), 16'(w.len), "length");
        cmp(16'(bad_mode), 16'(w.bad), "bad mode");
      end
    end
  end

  initial begin
    #(25 * 20000);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp(16'(byte_ready), 16'h0000, "ready in reset");
    cmp(16'(ea_valid), 16'h0000, "valid in reset");
    cmp(16'(mem_req), 16'h0000, "req in reset");
    cmp(16'(mode_out), 16'(M_INH), "mode in reset");
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    $display("Test reset done");
    run(8'h00, M_INH, 1'b0, 8'h00, 8'h00);
    run(8'h00, M_IMM, 1'b0, 8'h55, 8'h00);
    run(8'h00, M_DIR_S, 1'b0, 8'hFF, 8'h00);
    run(8'h00, M_DIR_L, 1'b0, 8'hFF, 8'hFE);
    run(8'h00, M_IDX_0, 1'b0, 8'h00, 8'h00);
    $display("Test plain modes done");
    run(8'h00, M_IDX_S, 1'b0, 8'hFF, 8'h00);
    run(8'h00, M_IDX_L, 1'b0, 8'hFF, 8'hFF);
    run(PREFIX_SECOND, M_IDX_S, 1'b0, 8'hC3, 8'h00);
    run(PREFIX_SECOND, M_IDX_0, 1'b0, 8'h00, 8'h00);
    $display("Test indexed done");
    lat <= 2'h3;
    run(PREFIX_INDIRECT, M_DIR_S, 1'b0, 8'h10, 8'h00);
    run(PREFIX_INDIRECT, M_DIR_L, 1'b0, 8'hFF, 8'h00);
    lat <= 2'h0;
    run(PREFIX_INDIRECT, M_DIR_L, 1'b0, 8'h42, 8'h00);
    $display("Test indirect done");
    run(8'h00, M_REL_D, 1'b0, 8'h80, 8'h00);
    run(8'h00, M_REL_D, 1'b0, 8'h7F, 8'h00);
    run(8'h00, M_DIR_L, 1'b1, 8'h12, 8'h34);
    run(8'h00, M_IDX_S, 1'b1, 8'h12, 8'h00);
    $display("Test relative and rmw done");
    run(PREFIX_INDIRECT, M_IDX_S, 1'b0, 8'h20, 8'h00);
    run(PREFIX_INDIRECT, M_IDX_L, 1'b1, 8'h30, 8'h00);
    run(PREFIX_INDIRECT, M_REL_D, 1'b0, 8'h40, 8'h00);
    run(8'h00, M_BIT_D, 1'b1, 8'h77, 8'h00);
    run(PREFIX_INDIRECT, M_BIT_D, 1'b1, 8'h50, 8'h00);
    run(8'h00, M_BITREL_D, 1'b0, 8'h66, 8'h81);
    run(PREFIX_INDIRECT, M_BITREL_D, 1'b0, 8'h60, 8'h7F);
    $display("Test converted and bit modes done");
    for (i = 0; i < 24; i++) begin
      lat <= 2'($random(seed));
      rb = 8'($random(seed));
      case (3'($random(seed)))
        3'h0: run(8'h00, M_IMM, 1'b0, rb, 8'h00);
        3'h1: run(8'h00, M_DIR_S, 1'b1, rb, 8'h00);
        3'h2: run(8'h00, M_DIR_L, 1'b1, rb, 8'h5A);
        3'h3: run(8'h00, M_IDX_L, 1'b0, rb, 8'hF0);
        3'h4: run(PREFIX_SECOND, M_IDX_S, 1'b0, rb, 8'h00);
        3'h5: run(PREFIX_INDIRECT, M_DIR_L, 1'b0, rb, 8'h00);
        3'h6: run(8'h00, M_REL_D, 1'b0, rb, 8'h00);
        default: run(PREFIX_INDIRECT, M_DIR_S, 1'b0, rb, 8'h00);
      endcase
    end
    $display("Test random mix done");
    close_out();
  end
endmodule
